// ### arf_defines.svh
/*
   Register indices, field positions, reset values and timing counts of the
   rate and false-alarm filter configuration block.
   Assumes inclusion by its bare name from any file that needs the figures.
*/
`ifndef ARF_DEFINES_SVH
`define ARF_DEFINES_SVH

// ==========================================================================
// Register indices; the bus byte address is four times the index.
`define ARF_STAT_IDX      8'h40
`define ARF_CFG0_IDX      8'h4c
`define ARF_CFG1_IDX      8'h4d
`define ARF_IDX_W         8

// ==========================================================================
// Field positions and reset values.
`define ARF_ANY_ALARM_BIT 6
`define ARF_RATE_LSB      8
`define ARF_CHF_LSB       5
`define ARF_TMF_LSB       3
`define ARF_CFG1_RST      16'h0070
`define ARF_RATE_RST      2'h0
`define ARF_CHF_RST       3'h3
`define ARF_TMF_RST       2'h2

// ==========================================================================
// Timing: the full conversion rate and the clock rate, both in kHz.
`define ARF_CLK_KHZ       10000
`define ARF_BASE_KSPS     500
`define ARF_BASE_CYC      (`ARF_CLK_KHZ / `ARF_BASE_KSPS)

// ==========================================================================
// Bus response codes.
`define ARF_RESP_OKAY     2'h0
`define ARF_RESP_SLVERR   2'h2

`endif

// ### arf_pkg.sv
/*
   Types shared by the rate and false-alarm filter configuration block.
   Assumes arf_defines.svh supplies the numeric constants.
*/
package arf_pkg;

   // ========================================================================
   // Configuration fields as they leave the register.
   typedef struct packed {
      logic [1:0] rate_sel;
      logic [2:0] chan_filt;
      logic [1:0] temp_filt;
   } arf_cfg_t;

   // ========================================================================
   // Read channel states, one-hot.
   typedef enum logic [1:0] {
      ARF_RD_IDLE = 2'b01,
      ARF_RD_RESP = 2'b10
   } arf_rd_state_t;

endpackage

// ### arf_top.sv
/*
   Rate and false-alarm filter configuration registers with alarm status,
   reached over an AXI4-Lite slave port.
   Assumes one 10 MHz clock, a synchronous active-low reset, and that the
   sample strobes and out-of-range flags are synchronous to that clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "arf_defines.svh"

module arf_top #(
   parameter int NCH    = 4,
   parameter int NTEMP  = 3,
   parameter int ADDR_W = 12
) (
   // Clock and reset.
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // AXI4-Lite write address and data.
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Samples: channels in the low bits, temperature monitors above them.
   input  wire logic [NCH+NTEMP-1:0]  smp_valid,
   input  wire logic [NCH+NTEMP-1:0]  smp_out_of_range,
   // Block outputs.
   output logic                       conv_start,
   output arf_pkg::arf_cfg_t          cfg,
   output logic [NCH+NTEMP-1:0]       alarm_bits,
   output logic                       any_alarm_flag
);
   import arf_pkg::*;

   localparam int NSRC = NCH + NTEMP;
   localparam logic [7:0] BASE_CYC = 8'(`ARF_BASE_CYC);

   // =======================================================================
   // Shared declarations.
   arf_cfg_t             cfg_q, cfg_d;
   logic [NSRC-1:0]      stat_q, stat_d;
   logic                 any_q, any_d;
   logic [NSRC-1:0]      hit;
   logic                 stat_rd_clr;

   // Write channel state.
   logic                 aw_have_q, aw_have_d;
   logic [ADDR_W-1:0]    aw_addr_q, aw_addr_d;
   logic                 w_have_q, w_have_d;
   logic [31:0]          w_data_q, w_data_d;
   logic [3:0]           w_strb_q, w_strb_d;
   logic                 awready_q, awready_d;
   logic                 wready_q, wready_d;
   logic                 bvalid_q, bvalid_d;
   logic [1:0]           bresp_q, bresp_d;

   // Read channel state.
   arf_rd_state_t        rd_q, rd_d;
   logic                 arready_q, arready_d;
   logic [31:0]          rdata_q, rdata_d;
   logic [1:0]           rresp_q, rresp_d;

   // Rate divider state.
   logic [7:0]           div_q, div_d;
   logic                 conv_q, conv_d;

   // =======================================================================
   // Register word as software sees it; unlisted bits stay zero.
   function automatic logic [31:0] read_word(input logic [`ARF_IDX_W-1:0] idx);
      logic [31:0] w;
      w = 32'h0;
      case (idx)
         `ARF_STAT_IDX: w[NSRC-1:0] = stat_q;
         `ARF_CFG0_IDX: w[`ARF_ANY_ALARM_BIT] = any_q;
         `ARF_CFG1_IDX: begin
            w[`ARF_RATE_LSB +: 2] = cfg_q.rate_sel;
            w[`ARF_CHF_LSB +: 3]  = cfg_q.chan_filt;
            w[`ARF_TMF_LSB +: 2]  = cfg_q.temp_filt;
         end
         default: w = 32'h0;
      endcase
      return w;
   endfunction

   // Decoded register index of a byte address.
   function automatic logic [`ARF_IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
      return a[`ARF_IDX_W+1:2];
   endfunction

   // Whether an index names a register at all.
   function automatic logic is_mapped(input logic [`ARF_IDX_W-1:0] idx);
      return (idx == `ARF_STAT_IDX) || (idx == `ARF_CFG0_IDX) || (idx == `ARF_CFG1_IDX);
   endfunction

   // =======================================================================
   // Write channel: address and data are taken independently, and the write
   // takes effect once both are held and no response is pending.
   always_comb begin
      logic                   do_wr;
      logic [`ARF_IDX_W-1:0]  widx;
      logic [15:0]            cur;
      logic [15:0]            nxt;
      do_wr     = 1'b0;
      widx      = idx_of(aw_addr_q);
      cur       = 16'(read_word(`ARF_CFG1_IDX));
      nxt       = cur;
      aw_have_d = aw_have_q;
      aw_addr_d = aw_addr_q;
      w_have_d  = w_have_q;
      w_data_d  = w_data_q;
      w_strb_d  = w_strb_q;
      bvalid_d  = bvalid_q && !s_axi_bready;                        // Response leaves once taken.
      bresp_d   = bresp_q;
      cfg_d     = cfg_q;
      if (s_axi_awvalid && awready_q) begin
         aw_have_d = 1'b1;
         aw_addr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
         w_have_d = 1'b1;
         w_data_d = s_axi_wdata;
         w_strb_d = s_axi_wstrb;
      end
      if (aw_have_q && w_have_q && !bvalid_q) begin
         do_wr     = 1'b1;
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = is_mapped(widx) ? `ARF_RESP_OKAY : `ARF_RESP_SLVERR;
      end
      // Byte lanes merge into the current value; only the writable fields
      // are picked back out, so reserved positions keep no state.
      nxt[7:0]  = w_strb_q[0] ? w_data_q[7:0] : cur[7:0];
      nxt[15:8] = w_strb_q[1] ? w_data_q[15:8] : cur[15:8];
      if (do_wr && (widx == `ARF_CFG1_IDX)) begin
         cfg_d.rate_sel  = nxt[`ARF_RATE_LSB +: 2];
         cfg_d.chan_filt = nxt[`ARF_CHF_LSB +: 3];
         cfg_d.temp_filt = nxt[`ARF_TMF_LSB +: 2];
      end
      awready_d = !aw_have_d && !bvalid_d;
      wready_d  = !w_have_d && !bvalid_d;
   end

   // Write channel and configuration registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_have_q  <= 1'b0;
         w_data_q  <= 32'h0;
         w_strb_q  <= 4'h0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `ARF_RESP_OKAY;
         cfg_q.rate_sel  <= `ARF_RATE_RST;
         cfg_q.chan_filt <= `ARF_CHF_RST;
         cfg_q.temp_filt <= `ARF_TMF_RST;
      end else begin
         aw_have_q <= aw_have_d;
         aw_addr_q <= aw_addr_d;
         w_have_q  <= w_have_d;
         w_data_q  <= w_data_d;
         w_strb_q  <= w_strb_d;
         awready_q <= awready_d;
         wready_q  <= wready_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         cfg_q     <= cfg_d;
      end
   end

   // =======================================================================
   // Read channel: one read at a time, answered the cycle after it is taken.
   always_comb begin
      logic [`ARF_IDX_W-1:0] ridx;
      ridx        = idx_of(s_axi_araddr);
      rd_d        = rd_q;
      rdata_d     = rdata_q;
      rresp_d     = rresp_q;
      stat_rd_clr = 1'b0;
      case (rd_q)
         ARF_RD_IDLE: begin
            if (s_axi_arvalid && arready_q) begin
               rd_d        = ARF_RD_RESP;
               rdata_d     = read_word(ridx);
               rresp_d     = is_mapped(ridx) ? `ARF_RESP_OKAY : `ARF_RESP_SLVERR;
               stat_rd_clr = (ridx == `ARF_STAT_IDX);
            end
         end
         ARF_RD_RESP: begin
            if (s_axi_rready) begin
               rd_d = ARF_RD_IDLE;
            end
         end
         default: rd_d = ARF_RD_IDLE;
      endcase
      arready_d = (rd_d == ARF_RD_IDLE);
   end

   // Read channel registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_q      <= ARF_RD_IDLE;
         arready_q <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= `ARF_RESP_OKAY;
      end else begin
         rd_q      <= rd_d;
         arready_q <= arready_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
   end

   // =======================================================================
   // Conversion rate divider: one start pulse per sample period, the period
   // stretched by a power of two from the rate select.
   always_comb begin
      logic [7:0] period;
      period = BASE_CYC << cfg_q.rate_sel;
      conv_d = (div_q >= period - 8'h1);
      div_d  = conv_d ? 8'h0 : div_q + 8'h1;
   end

   // Divider registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q  <= 8'h0;
         conv_q <= 1'b0;
      end else begin
         div_q  <= div_d;
         conv_q <= conv_d;
      end
   end

   // =======================================================================
   // Consecutive-sample filters, one per source.
   for (genvar i = 0; i < NSRC; i++) begin : g_src
      logic [8:0] cnt_q, cnt_d;
      logic [8:0] thr;

      // Threshold from the filter code of this source's group.
      always_comb begin
         if (i < NCH) begin
            thr = (cfg_q.chan_filt == 3'h0) ? 9'h1
                                            : 9'h1 << ({1'b0, cfg_q.chan_filt} + 4'h1);
         end else begin
            thr = 9'h1 << cfg_q.temp_filt;
         end
      end

      // Count the run; the count saturates at the threshold so a long run
      // cannot wrap round and fall silent.
      always_comb begin
         cnt_d  = cnt_q;
         hit[i] = 1'b0;
         if (smp_valid[i]) begin
            if (smp_out_of_range[i]) begin
               hit[i] = ({1'b0, cnt_q} + 10'h1) >= {1'b0, thr};
               cnt_d  = (cnt_q >= thr) ? cnt_q : cnt_q + 9'h1;
            end else begin
               cnt_d = 9'h0;
            end
         end
      end

      // Run counter.
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            cnt_q <= 9'h0;
         end else begin
            cnt_q <= cnt_d;
         end
      end
   end

   // =======================================================================
   // Sticky status bits and the global flag. A new alarm in the cycle of the
   // clearing read survives it, so no event is lost between read and clear.
   always_comb begin
      stat_d = (stat_q & ~{NSRC{stat_rd_clr}}) | hit;
      any_d  = |stat_d;
   end

   // Status registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= '0;
         any_q  <= 1'b0;
      end else begin
         stat_q <= stat_d;
         any_q  <= any_d;
      end
   end

   // =======================================================================
   // Outputs, each straight from a flip-flop.
   assign s_axi_awready  = awready_q;
   assign s_axi_wready   = wready_q;
   assign s_axi_bvalid   = bvalid_q;
   assign s_axi_bresp    = bresp_q;
   assign s_axi_arready  = arready_q;
   assign s_axi_rvalid   = rd_q[1];                                 // One-hot answer state bit.
   assign s_axi_rdata    = rdata_q;
   assign s_axi_rresp    = rresp_q;
   assign conv_start     = conv_q;
   assign cfg            = cfg_q;
   assign alarm_bits     = stat_q;
   assign any_alarm_flag = any_q;

endmodule // arf_top

`default_nettype wire

// ### arf_top_properties.sv
/* Checker for arf_top: alarm flag, readback, filters and rate.
   Assumes it is bound to arf_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module arf_top_properties #(
   parameter int NCH    = 4,
   parameter int NTEMP  = 3,
   parameter int ADDR_W = 12
) (
   // Clock and reset.
   input wire logic                 aclk,
   input wire logic                 aresetn,
   // Read bus.
   input wire logic [ADDR_W-1:0]    s_axi_araddr,
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire logic [31:0]          s_axi_rdata,
   input wire logic                 s_axi_rvalid,
   // Samples and block outputs.
   input wire logic [NCH+NTEMP-1:0] smp_valid,
   input wire logic [NCH+NTEMP-1:0] smp_out_of_range,
   input wire logic                 conv_start,
   input wire arf_pkg::arf_cfg_t    cfg,
   input wire logic [NCH+NTEMP-1:0] alarm_bits,
   input wire logic                 any_alarm_flag
);
   import arf_pkg::*;
   logic [ADDR_W-1:0] ar_q;
   logic [15:0]       cnt_q;
   logic [1:0]        rate_q;
   logic              seen_q;
   logic              chg_q;
   logic              rd_stat;
   // ======================================================================
   // Helpers: last read address and the spacing of rate pulses.
   // A pulse right after a rate change is skipped, since the divider keeps its count.
   assign rd_stat = s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADDR_W'(12'h100));
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_q   <= '0;
         cnt_q  <= 16'h0;
         rate_q <= 2'h0;
         seen_q <= 1'b0;
         chg_q  <= 1'b0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
         cnt_q  <= conv_start ? 16'h1 : cnt_q + 16'h1;
         rate_q <= cfg.rate_sel;
         seen_q <= seen_q | conv_start;
         chg_q  <= (cfg.rate_sel != rate_q) | (chg_q & !conv_start);
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ======================================================================
   // Assertions and covers.
   a_flag_is_or: assert property (any_alarm_flag == (|alarm_bits))
      else $error("alarm flag differs from OR of status bits");
   a_flag_holds: assert property (any_alarm_flag && !rd_stat |=> any_alarm_flag)
      else $error("alarm flag dropped without a status read");
   a_read_clears: assert property (rd_stat && !(|(smp_valid & smp_out_of_range))
      |=> !any_alarm_flag && alarm_bits == '0)
      else $error("status read did not clear the alarms");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
      else $error("upper read bits not zero");
   a_cfg_readback: assert property (s_axi_rvalid && ar_q == ADDR_W'(12'h134)
      |-> s_axi_rdata[15:0] == {6'h0, cfg.rate_sel, cfg.chan_filt, cfg.temp_filt, 3'h0})
      else $error("config readback mismatch");
   a_cfg_reset: assert property ($rose(aresetn) |-> cfg == arf_cfg_t'(7'h0e))
      else $error("config reset value wrong");
   a_rate_period: assert property (conv_start && seen_q && !chg_q && cfg.rate_sel == rate_q
      |-> cnt_q == (16'h14 << cfg.rate_sel))
      else $error("conversion period wrong");
   a_chan_single: assert property (smp_valid[0] && smp_out_of_range[0] && cfg.chan_filt == 3'h0
      |=> alarm_bits[0] && any_alarm_flag)
      else $error("channel alarm late at code 0");
   a_temp_single: assert property (smp_valid[NCH] && smp_out_of_range[NCH] && cfg.temp_filt == 2'h0
      |=> alarm_bits[NCH] && any_alarm_flag)
      else $error("temperature alarm late at code 0");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   c_alarm: cover property ($rose(any_alarm_flag));
   c_stat_read: cover property (rd_stat && any_alarm_flag);
   c_slow_rate: cover property (conv_start && cfg.rate_sel == 2'h3);
endmodule // arf_top_properties
bind arf_top arf_top_properties #(.NCH(NCH), .NTEMP(NTEMP), .ADDR_W(ADDR_W)) u_props (
   .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .smp_valid, .smp_out_of_range, .conv_start, .cfg, .alarm_bits, .any_alarm_flag);
`default_nettype wire

// ### arf_host_model.sv
/* Host side model: an AXI4-Lite master with one write and one read task.
   Assumes a single clock; the bench calls the tasks hierarchically. */
`timescale 1ns/1ps
`default_nettype none
module arf_host_model (
   // Clock.
   input wire logic         aclk,
   // Write channels.
   output logic [11:0]      s_axi_awaddr,
   output logic             s_axi_awvalid,
   input wire logic         s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input wire logic         s_axi_wready,
   input wire logic [1:0]   s_axi_bresp,
   input wire logic         s_axi_bvalid,
   output logic             s_axi_bready,
   // Read channels.
   output logic [11:0]      s_axi_araddr,
   output logic             s_axi_arvalid,
   input wire logic         s_axi_arready,
   output logic             s_axi_rready,
   input wire logic         s_axi_rvalid
);
   // Idle bus at time zero so nothing is offered during reset.
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
   end
   // Each channel is released at the edge that takes it; no cycle count is assumed.
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
endmodule // arf_host_model
`default_nettype wire

// ### arf_top_bench.sv
/* Self-checking bench for arf_top: reads are scored from a queue.
   Assumes arf_host_model and the checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
`include "arf_defines.svh"
module arf_top_bench;
   import arf_pkg::*;
   localparam logic [11:0] A_STAT = 12'(`ARF_STAT_IDX * 4);
   localparam logic [11:0] A_CFG0 = 12'(`ARF_CFG0_IDX * 4);
   localparam logic [11:0] A_CFG1 = 12'(`ARF_CFG1_IDX * 4);
   logic        aclk = 1'b0, aresetn = 1'b0, conv_start, any_alarm_flag;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, wd;
   logic [33:0] exp_q[$];
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [6:0]  smp_valid = 7'h0, smp_oor = 7'h0, alarm_bits;
   arf_cfg_t    cfg;
   int          n_errors = 0, n_tests = 0, seed = 32'hae66b777, k, n;
   always #50 aclk = ~aclk;
   arf_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .smp_valid, .smp_out_of_range(smp_oor), .conv_start, .cfg, .alarm_bits,
      .any_alarm_flag);
   arf_host_model u_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rready, .s_axi_rvalid);
   // ======================================================================
   // Compare, verdict and sample strobes.
   task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic strobe(input int src, input logic oor);
      @(posedge aclk);
      smp_valid <= 7'h1 << src;
      smp_oor   <= oor ? 7'h1 << src : 7'h0;
      @(posedge aclk);
      smp_valid <= 7'h0;
   endtask
   // A broken run of n-1 must not alarm; an unbroken run of n must.
   task automatic filt(input int src, input logic [31:0] d, input int cnt);
      u_host.wr(A_CFG1, d, resp);
      repeat (cnt - 1) strobe(src, 1'b1);
      strobe(src, 1'b0);
      repeat (cnt - 1) strobe(src, 1'b1);
      @(posedge aclk); chk("early", alarm_bits, 7'h0);
      strobe(src, 1'b1);
      repeat (2) @(posedge aclk); chk("alarm", alarm_bits, 7'h1 << src);
      strobe(src, 1'b0);
      strobe(src, 1'b0);
      @(posedge aclk); chk("hold", any_alarm_flag, 1'b1);
      // The flag also reads back from the other configuration word, without clearing.
      exp_q.push_back(34'h1 << `ARF_ANY_ALARM_BIT);
      u_host.rd(A_CFG0);
      exp_q.push_back(34'h1 << src);
      u_host.rd(A_STAT);
      @(posedge aclk); chk("clear", {alarm_bits, any_alarm_flag}, 8'h0);
   endtask
   task automatic wait_pulse(output int cyc);
      cyc = 0;
      do begin @(posedge aclk); cyc++; end while (!conv_start && cyc < 2000);
   endtask
   // Scoreboard: every read answer takes the oldest expectation.
   always @(posedge aclk) begin
      if (aresetn && s_axi_rvalid && s_axi_rready) begin
         chk("rdata", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      end
   end
   initial begin
      #2000000;
      n_errors++;
      finish_test();
   end
   // ======================================================================
   // Main sequence.
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk); chk("cfg", cfg, 7'h0e);
      exp_q.push_back(34'h70);
      u_host.rd(A_CFG1);
      exp_q.push_back(34'h0);
      u_host.rd(A_STAT);
      for (k = 0; k < 4; k++) begin
         wd = (k == 0) ? 32'hffffffff : $random(seed);
         u_host.wr(A_CFG1, wd, resp); chk("bresp", resp, 2'h0);
         exp_q.push_back(wd & 32'h3f8);
         u_host.rd(A_CFG1);
      end
      // Unmapped and read-only words take the write and keep nothing.
      u_host.wr(12'h200, 32'hffffffff, resp); chk("bresp", resp, 2'h2);
      exp_q.push_back(34'h2_0000_0000);
      u_host.rd(12'h200);
      u_host.wr(A_CFG0, 32'hffffffff, resp); chk("bresp", resp, 2'h0);
      exp_q.push_back(34'h0);
      u_host.rd(A_CFG0);
      exp_q.push_back(wd & 32'h3f8);
      u_host.rd(A_CFG1);
      for (k = 0; k < 4; k++) begin
         u_host.wr(A_CFG1, 32'h70 | (k << 8), resp);
         repeat (3) wait_pulse(n);
         chk("period", n, `ARF_BASE_CYC << k);
      end
      for (k = 0; k < 8; k++) filt($unsigned($random(seed)) % 4, (k << 5) | 32'h10, (k == 0) ? 1 : 4 << (k - 1));
      for (k = 0; k < 4; k++) filt(4 + $unsigned($random(seed)) % 3, 32'h60 | (k << 3), 1 << k);
      finish_test();
   end
endmodule // arf_top_bench
`default_nettype wire
